//--- afp_defines.svh
// Purpose: constants for the alu flags and port read-modify-write slice
// Assumes: 8-bit datapath
// Notes: reset values, decimal adjust constants, result limits and divide step count
`ifndef AFP_DEFINES_SVH
`define AFP_DEFINES_SVH
`define AFP_ACC_RESET   8'h00
`define AFP_PART_RESET  8'h00
`define AFP_LATCH_RESET 8'hff
`define AFP_NIBBLE_MAX  4'h9
`define AFP_DA_LOW_ADJ  8'h06
`define AFP_DA_HIGH_ADJ 8'h60
`define AFP_BCD_MAX     9'h099
`define AFP_BYTE_MAX    16'h00ff
`define AFP_DIV_STEPS   4'h8
`endif

//--- afp_pkg.sv
// Purpose: types for the alu flags and port read-modify-write slice
// Assumes: none
// Notes: opcode list is the datapath's own encoding
package afp_pkg;
  typedef enum logic [4:0] {
    AFP_OP_NOP    = 5'h00,
    AFP_OP_ADD    = 5'h01,
    AFP_OP_ADDC   = 5'h02,
    AFP_OP_SUBB   = 5'h03,
    AFP_OP_MUL    = 5'h04,
    AFP_OP_DIV    = 5'h05,
    AFP_OP_DA     = 5'h06,
    AFP_OP_RRC    = 5'h07,
    AFP_OP_RLC    = 5'h08,
    AFP_OP_P_ANL  = 5'h09,
    AFP_OP_P_ORL  = 5'h0a,
    AFP_OP_P_XRL  = 5'h0b,
    AFP_OP_P_JBC  = 5'h0c,
    AFP_OP_P_CPL  = 5'h0d,
    AFP_OP_P_INC  = 5'h0e,
    AFP_OP_P_DEC  = 5'h0f,
    AFP_OP_P_DJNZ = 5'h10,
    AFP_OP_P_MOVC = 5'h11,
    AFP_OP_P_CLR  = 5'h12,
    AFP_OP_P_SETB = 5'h13,
    AFP_OP_P_RDB  = 5'h14,
    AFP_OP_P_RDP  = 5'h15
  } afp_op_t;
  typedef enum logic [1:0] {
    AFP_ST_IDLE = 2'b00,
    AFP_ST_DIV  = 2'b01,
    AFP_ST_DONE = 2'b11
  } afp_state_t;
endpackage

//--- afp_adder.sv
// Purpose: 8-bit add or subtract with carries out of bits 3, 6 and 7
// Assumes: sub high means a - b - cin with borrows
// Notes: borrow is the inverted carry of a + ~b + ~cin
`timescale 1ns/1ns
module afp_adder (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  wire logic       sub,
  output logic      [7:0] sum,
  output logic            c3,
  output logic            c6,
  output logic            c7
);
  wire logic [7:0] b_eff  = sub ? ~b : b;
  wire logic       ci_eff = sub ? ~cin : cin;
  wire logic [4:0] lo     = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, ci_eff};
  wire logic [3:0] mid    = {1'b0, a[6:4]} + {1'b0, b_eff[6:4]} + {3'h0, lo[4]};
  wire logic [1:0] hi     = {1'b0, a[7]} + {1'b0, b_eff[7]} + {1'b0, mid[3]};
  assign sum = {hi[0], mid[2:0], lo[3:0]};
  assign c3  = sub ? ~lo[4]  : lo[4];
  assign c6  = sub ? ~mid[3] : mid[3];
  assign c7  = sub ? ~hi[1]  : hi[1];
endmodule

//--- afp_divider.sv
// Purpose: unsigned 8-bit restoring divider, one quotient bit per cycle
// Assumes: start is a one-cycle pulse while idle
// Notes: a zero divisor still runs; results are then undefined by design
`timescale 1ns/1ns
`include "afp_defines.svh"
module afp_divider
  import afp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] dividend,
  input  wire logic [WIDTH-1:0] divisor,
  output logic      [WIDTH-1:0] quotient,
  output logic      [WIDTH-1:0] remainder,
  output logic                  done
);
  logic [WIDTH-1:0] quo_q;
  logic [WIDTH-1:0] rem_q;
  logic [WIDTH-1:0] den_q;
  logic [3:0]       cnt_q;
  logic             busy_q;
  logic             done_q;
  wire logic [WIDTH:0]   trial = {rem_q, quo_q[WIDTH-1]};
  wire logic             fits  = trial >= {1'b0, den_q};
  wire logic [WIDTH:0]   diff  = trial - {1'b0, den_q};
  wire logic [WIDTH-1:0] rem_n = fits ? diff[WIDTH-1:0] : trial[WIDTH-1:0];
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      quo_q  <= '0;
      rem_q  <= '0;
      den_q  <= '0;
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        quo_q  <= dividend;
        rem_q  <= '0;
        den_q  <= divisor;
        cnt_q  <= `AFP_DIV_STEPS;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rem_q  <= rem_n;
        quo_q  <= {quo_q[WIDTH-2:0], fits};
        cnt_q  <= cnt_q - 4'h1;
        busy_q <= cnt_q != 4'h1;
        done_q <= cnt_q == 4'h1;
      end
    end
  end
  assign quotient  = quo_q;
  assign remainder = rem_q;
  assign done      = done_q;
endmodule

//--- afp_alu_flags_port_rmw.sv
// Purpose: accumulator datapath with status flags and port read-modify-write
// Assumes: op_valid is a one-cycle pulse taken only while ready is high
// Notes: divide takes ten cycles, everything else completes in one
// Operation
// - read-modify-write on a port reads the output latch, not the pins.
// - plain port bit input reads the pin level.
// - latch set: ANL, ORL, XRL, JBC, CPL, INC, DEC, DJNZ, MOV bit, CLR, SETB.
// - single-bit port writes rewrite the whole latch byte, altering one bit.
// - JBC on a port bit branches if latched bit set, then clears it.
// - ADD ignores carry in; carry set on carry out of bit 7.
// - ADDC adds accumulator, source and carry; same flag rules as ADD.
// - addition overflow is carry out of bit 6 xor bit 7.
// - addition nibble carry set on carry out of bit 3.
// - SUBB subtracts source and carry; carry set on borrow into bit 7.
// - subtraction overflow set when exactly one of bits 6, 7 borrows.
// - subtraction nibble carry set when bit 3 needs a borrow.
// - MUL puts product low byte in accumulator, high byte in partner.
// - after MUL carry clears; overflow set when product exceeds 255.
// - DIV puts quotient in accumulator, remainder in partner, clears carry.
// - DIV overflow clear unless divisor zero; then set, results undefined.
// - decimal adjust adds 0x06 if nibble carry or low nibble above 9.
// - then adds 0x60 if carry was set or low correction was added.
// - decimal adjust sets carry when result exceeds 0x99, else clears.
// - RRC moves bit 0 to carry and old carry into bit 7.
// - RLC moves bit 7 to carry and old carry into bit 0.
`timescale 1ns/1ns
`include "afp_defines.svh"
module afp_alu_flags_port_rmw
  import afp_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       op_valid,
  input  wire afp_op_t    op_code,
  input  wire logic [7:0] src_data,
  input  wire logic [2:0] bit_sel,
  input  wire logic [7:0] port_pins,
  output logic            ready,
  output logic            op_done,
  output logic [7:0]      accumulator_reg,
  output logic [7:0]      partner_reg,
  output logic            carry_flag,
  output logic            signed_overflow_flag,
  output logic            nibble_carry_flag,
  output logic [7:0]      port_latch,
  output logic            branch_taken,
  output logic            bit_result
);
  afp_state_t state_q;
  afp_state_t state_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [7:0] part_q;
  logic [7:0] part_d;
  logic       cy_q;
  logic       cy_d;
  logic       ov_q;
  logic       ov_d;
  logic       ac_q;
  logic       ac_d;
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic       br_q;
  logic       br_d;
  logic       bit_q;
  logic       bit_d;
  logic       done_q;
  logic       done_d;

  wire logic take = op_valid && state_q == AFP_ST_IDLE;

  // add and subtract share one carry chain
  wire logic       is_sub  = op_code == AFP_OP_SUBB;
  wire logic       add_cin = (op_code == AFP_OP_ADD) ? 1'b0 : cy_q;
  wire logic [7:0] add_sum;
  wire logic       add_c3;
  wire logic       add_c6;
  wire logic       add_c7;
  afp_adder u_adder (
    .a   (acc_q),
    .b   (src_data),
    .cin (add_cin),
    .sub (is_sub),
    .sum (add_sum),
    .c3  (add_c3),
    .c6  (add_c6),
    .c7  (add_c7)
  );

  wire logic [15:0] product = {8'h00, acc_q} * {8'h00, part_q};

  wire logic       div_start = take && op_code == AFP_OP_DIV;
  wire logic [7:0] div_quo;
  wire logic [7:0] div_rem;
  wire logic       div_done;
  afp_divider #(
    .WIDTH (8)
  ) u_divider (
    .clock     (clock),
    .reset     (reset),
    .start     (div_start),
    .dividend  (acc_q),
    .divisor   (part_q),
    .quotient  (div_quo),
    .remainder (div_rem),
    .done      (div_done)
  );

  wire logic       da_low  = ac_q || (acc_q[3:0] > `AFP_NIBBLE_MAX);
  wire logic [8:0] da_s1   = {1'b0, acc_q} + (da_low ? {1'b0, `AFP_DA_LOW_ADJ} : 9'h000);
  wire logic       da_high = cy_q || da_low;
  wire logic [8:0] da_s2   = da_s1 + (da_high ? {1'b0, `AFP_DA_HIGH_ADJ} : 9'h000);

  // latch is the source for every read-modify-write
  wire logic [7:0] rmw_src  = latch_q;
  wire logic [7:0] bit_mask = 8'h01 << bit_sel;
  wire logic       rmw_bit  = |(rmw_src & bit_mask);
  // plain bit input from the pins
  wire logic       pin_bit  = |(port_pins & bit_mask);
  wire logic [7:0] rmw_dec  = rmw_src - 8'h01;

  always_comb begin
    state_d = state_q;
    acc_d   = acc_q;
    part_d  = part_q;
    cy_d    = cy_q;
    ov_d    = ov_q;
    ac_d    = ac_q;
    latch_d = latch_q;
    br_d    = 1'b0;
    bit_d   = bit_q;
    done_d  = 1'b0;
    case (state_q)
      AFP_ST_IDLE: begin
        if (take) begin
          done_d = op_code != AFP_OP_DIV;
          case (op_code)
            // same flag update for both addition forms
            AFP_OP_ADD, AFP_OP_ADDC: begin
              acc_d = add_sum;
              cy_d  = add_c7;
              // overflow from bit 6 and bit 7 carries
              ov_d  = add_c6 ^ add_c7;
              ac_d  = add_c3;
            end
            AFP_OP_SUBB: begin
              acc_d = add_sum;
              cy_d  = add_c7;
              ov_d  = add_c6 ^ add_c7;
              ac_d  = add_c3;
            end
            AFP_OP_MUL: begin
              acc_d  = product[7:0];
              part_d = product[15:8];
              cy_d   = 1'b0;
              ov_d   = product > `AFP_BYTE_MAX;
            end
            AFP_OP_DIV: begin
              state_d = AFP_ST_DIV;
            end
            AFP_OP_DA: begin
              acc_d = da_s2[7:0];
              cy_d  = da_s2 > `AFP_BCD_MAX;
            end
            AFP_OP_RRC: begin
              acc_d = {cy_q, acc_q[7:1]};
              cy_d  = acc_q[0];
            end
            AFP_OP_RLC: begin
              acc_d = {acc_q[6:0], cy_q};
              cy_d  = acc_q[7];
            end
            AFP_OP_P_ANL: latch_d = rmw_src & src_data;
            AFP_OP_P_ORL: latch_d = rmw_src | src_data;
            AFP_OP_P_XRL: latch_d = rmw_src ^ src_data;
            AFP_OP_P_INC: latch_d = rmw_src + 8'h01;
            AFP_OP_P_DEC: latch_d = rmw_dec;
            AFP_OP_P_DJNZ: begin
              latch_d = rmw_dec;
              br_d    = rmw_dec != 8'h00;
            end
            AFP_OP_P_JBC: begin
              // branch on latched one, then clear
              br_d    = rmw_bit;
              latch_d = rmw_src & ~bit_mask;
              bit_d   = rmw_bit;
            end
            // whole byte rewritten, one bit changed
            AFP_OP_P_CPL:  latch_d = rmw_src ^ bit_mask;
            AFP_OP_P_MOVC: latch_d = cy_q ? (rmw_src | bit_mask) : (rmw_src & ~bit_mask);
            AFP_OP_P_CLR:  latch_d = rmw_src & ~bit_mask;
            AFP_OP_P_SETB: latch_d = rmw_src | bit_mask;
            // pin sample for plain bit and byte reads
            AFP_OP_P_RDB:  bit_d = pin_bit;
            AFP_OP_P_RDP:  acc_d = port_pins;
            default: done_d = 1'b1;
          endcase
        end
      end
      AFP_ST_DIV: begin
        if (div_done) begin
          acc_d   = div_quo;
          part_d  = div_rem;
          cy_d    = 1'b0;
          ov_d    = part_q == 8'h00;
          done_d  = 1'b1;
          state_d = AFP_ST_DONE;
        end
      end
      AFP_ST_DONE: state_d = AFP_ST_IDLE;
      default: state_d = AFP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= AFP_ST_IDLE;
      acc_q   <= `AFP_ACC_RESET;
      part_q  <= `AFP_PART_RESET;
      cy_q    <= 1'b0;
      ov_q    <= 1'b0;
      ac_q    <= 1'b0;
      latch_q <= `AFP_LATCH_RESET;
      br_q    <= 1'b0;
      bit_q   <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      acc_q   <= acc_d;
      part_q  <= part_d;
      cy_q    <= cy_d;
      ov_q    <= ov_d;
      ac_q    <= ac_d;
      latch_q <= latch_d;
      br_q    <= br_d;
      bit_q   <= bit_d;
      done_q  <= done_d;
    end
  end

  assign ready                = state_q == AFP_ST_IDLE;
  assign op_done              = done_q;
  assign accumulator_reg      = acc_q;
  assign partner_reg          = part_q;
  assign carry_flag           = cy_q;
  assign signed_overflow_flag = ov_q;
  assign nibble_carry_flag    = ac_q;
  assign port_latch           = latch_q;
  assign branch_taken         = br_q;
  assign bit_result           = bit_q;
endmodule

//--- afp_alu_flags_port_rmw_properties.sv
// Purpose: concurrent checks on the alu flags and port read-modify-write slice
// Assumes: requests are taken on op_valid with ready; divide answers ten cycles later
// Notes: reference values are built from the inputs seen at the taking edge
`timescale 1ns/1ns
module afp_alu_flags_port_rmw_chk
  import afp_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       op_valid,
  input wire afp_op_t    op_code,
  input wire logic [7:0] src_data,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] port_pins,
  input wire logic       ready,
  input wire logic       op_done,
  input wire logic [7:0] accumulator_reg,
  input wire logic [7:0] partner_reg,
  input wire logic       carry_flag,
  input wire logic       signed_overflow_flag,
  input wire logic       nibble_carry_flag,
  input wire logic [7:0] port_latch,
  input wire logic       branch_taken,
  input wire logic       bit_result
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire logic        tk = op_valid && ready;
  wire logic        ci = (op_code == AFP_OP_ADD) ? 1'b0 : carry_flag;
  wire logic [8:0]  ad = {1'b0, accumulator_reg} + {1'b0, src_data} + {8'h00, ci};
  wire logic [7:0]  a6 = {1'b0, accumulator_reg[6:0]} + {1'b0, src_data[6:0]} + {7'h00, ci};
  wire logic [4:0]  a3 = {1'b0, accumulator_reg[3:0]} + {1'b0, src_data[3:0]} + {4'h0, ci};
  wire logic [8:0]  sb = {1'b0, accumulator_reg} - {1'b0, src_data} - {8'h00, carry_flag};
  wire logic [7:0]  s6 = {1'b0, accumulator_reg[6:0]} - {1'b0, src_data[6:0]} - {7'h00, carry_flag};
  wire logic [4:0]  s3 = {1'b0, accumulator_reg[3:0]} - {1'b0, src_data[3:0]} - {4'h0, carry_flag};
  wire logic [15:0] pr = {8'h00, accumulator_reg} * {8'h00, partner_reg};
  wire logic        pz = partner_reg == 8'h00;
  wire logic [7:0]  dq = pz ? 8'h00 : accumulator_reg / partner_reg;
  wire logic        lo = nibble_carry_flag || (accumulator_reg[3:0] > 4'h9);
  wire logic [8:0]  d1 = {1'b0, accumulator_reg} + (lo ? 9'h006 : 9'h000);
  wire logic [8:0]  d2 = d1 + ((carry_flag || lo) ? 9'h060 : 9'h000);
  wire logic [7:0]  bm = 8'h01 << bit_sel;
  property p_add;
    tk && (op_code == AFP_OP_ADD || op_code == AFP_OP_ADDC) |=>
      {accumulator_reg, carry_flag, signed_overflow_flag, nibble_carry_flag}
      == $past({ad[7:0], ad[8], ad[8] ^ a6[7], a3[4]});
  endproperty
  a_add: assert property (p_add) else $error("add result or flags wrong");
  property p_sub;
    tk && op_code == AFP_OP_SUBB |=>
      {accumulator_reg, carry_flag, signed_overflow_flag, nibble_carry_flag}
      == $past({sb[7:0], sb[8], sb[8] ^ s6[7], s3[4]});
  endproperty
  a_sub: assert property (p_sub) else $error("subtract result or flags wrong");
  property p_mul;
    tk && op_code == AFP_OP_MUL |=> {partner_reg, accumulator_reg} == $past(pr)
      && !carry_flag && signed_overflow_flag == ($past(pr) > 16'h00ff);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply result or flags wrong");
  property p_div;
    tk && op_code == AFP_OP_DIV |-> ##10 op_done && !carry_flag
      && signed_overflow_flag == $past(pz, 10) && ($past(pz, 10) || accumulator_reg == $past(dq, 10));
  endproperty
  a_div: assert property (p_div) else $error("divide result or flags wrong");
  property p_busy;
    tk && op_code == AFP_OP_DIV |=> !ready [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("ready during divide");
  property p_da;
    tk && op_code == AFP_OP_DA |=> accumulator_reg == $past(d2[7:0]) && carry_flag == $past(d2 > 9'h099);
  endproperty
  a_da: assert property (p_da) else $error("decimal adjust wrong");
  property p_rrc;
    tk && op_code == AFP_OP_RRC |=> {accumulator_reg, carry_flag} == $past({carry_flag, accumulator_reg});
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right wrong");
  property p_rlc;
    tk && op_code == AFP_OP_RLC |=> {carry_flag, accumulator_reg} == $past({accumulator_reg, carry_flag});
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left wrong");
  property p_bitw;
    tk && op_code == AFP_OP_P_CLR |=> port_latch == ($past(port_latch) & ~$past(bm));
  endproperty
  a_bitw: assert property (p_bitw) else $error("bit clear touched other latch bits");
  property p_jbc;
    tk && op_code == AFP_OP_P_JBC |=> branch_taken == $past(port_latch[bit_sel])
      && port_latch == ($past(port_latch) & ~$past(bm));
  endproperty
  a_jbc: assert property (p_jbc) else $error("bit test and clear wrong");
  property p_rdb;
    tk && op_code == AFP_OP_P_RDB |=> bit_result == $past(port_pins[bit_sel]);
  endproperty
  a_rdb: assert property (p_rdb) else $error("pin bit read wrong");
  c_div0: cover property (tk && op_code == AFP_OP_DIV && pz);
  c_jbc: cover property (tk && op_code == AFP_OP_P_JBC ##1 branch_taken);
  c_da: cover property (tk && op_code == AFP_OP_DA && carry_flag);
endmodule
bind afp_alu_flags_port_rmw afp_alu_flags_port_rmw_chk afp_alu_flags_port_rmw_chk_inst (
  .clock(clock), .reset(reset), .op_valid(op_valid), .op_code(op_code), .src_data(src_data),
  .bit_sel(bit_sel), .port_pins(port_pins), .ready(ready), .op_done(op_done),
  .accumulator_reg(accumulator_reg), .partner_reg(partner_reg), .carry_flag(carry_flag),
  .signed_overflow_flag(signed_overflow_flag), .nibble_carry_flag(nibble_carry_flag),
  .port_latch(port_latch), .branch_taken(branch_taken), .bit_result(bit_result));

//--- afp_alu_flags_port_rmw_tb.sv
// Purpose: self-checking bench for the alu flags and port read-modify-write slice
// Assumes: accumulator loads through a plain port read of the pins
// Notes: partner register is seeded by a divide by zero, whose remainder is the dividend
`timescale 1ns/1ns
module afp_alu_flags_port_rmw_tb
  import afp_pkg::*;
;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic       op_valid = 1'b0;
  afp_op_t    op_code = AFP_OP_NOP;
  logic [7:0] src_data = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] port_pins = 8'h00;
  logic       ready, op_done, carry_flag, signed_overflow_flag, nibble_carry_flag;
  logic       branch_taken, bit_result;
  logic [7:0] accumulator_reg, partner_reg, port_latch;
  int         errors = 0;
  int         n_compared = 0;
  always #50 clock = ~clock;
  afp_alu_flags_port_rmw afp_alu_flags_port_rmw_inst (
    .clock(clock), .reset(reset), .op_valid(op_valid), .op_code(op_code), .src_data(src_data),
    .bit_sel(bit_sel), .port_pins(port_pins), .ready(ready), .op_done(op_done),
    .accumulator_reg(accumulator_reg), .partner_reg(partner_reg), .carry_flag(carry_flag),
    .signed_overflow_flag(signed_overflow_flag), .nibble_carry_flag(nibble_carry_flag),
    .port_latch(port_latch), .branch_taken(branch_taken), .bit_result(bit_result));
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic op(input afp_op_t c, input logic [7:0] s, input logic [2:0] b);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    op_valid = 1'b1;
    op_code = c;
    src_data = s;
    bit_sel = b;
    @(posedge clock);
    #1;
    op_valid = 1'b0;
    n = 0;
    while (op_done !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 20) errors++;
  endtask
  task automatic ld(input logic [7:0] v);
    port_pins = v;
    op(AFP_OP_P_RDP, 8'h00, 3'h0);
  endtask
  task automatic fl(input logic [7:0] a, input logic c, input logic v, input logic n);
    cmp_byte(accumulator_reg, a);
    cmp_bit(carry_flag, c);
    cmp_bit(signed_overflow_flag, v);
    cmp_bit(nibble_carry_flag, n);
  endtask
  task automatic t_arith;
    fl(8'h00, 1'b0, 1'b0, 1'b0);
    cmp_byte(port_latch, 8'hff);
    ld(8'h78); op(AFP_OP_ADD, 8'h88, 3'h0); fl(8'h00, 1, 0, 1);
    op(AFP_OP_ADDC, 8'h00, 3'h0); fl(8'h01, 0, 0, 0);
    ld(8'h40); op(AFP_OP_ADD, 8'h40, 3'h0); fl(8'h80, 0, 1, 0);
    ld(8'h00); op(AFP_OP_SUBB, 8'h01, 3'h0); fl(8'hff, 1, 0, 1);
    ld(8'h80); op(AFP_OP_SUBB, 8'h00, 3'h0); fl(8'h7f, 0, 1, 1);
    $display("test arith done");
  endtask
  task automatic t_muldiv;
    ld(8'h10); op(AFP_OP_DIV, 8'h00, 3'h0); fl(8'hff, 0, 1, 1);
    cmp_bit(ready, 1'b0);
    ld(8'h20); op(AFP_OP_MUL, 8'h00, 3'h0); fl(8'h00, 0, 1, 1);
    cmp_byte(partner_reg, 8'h02);
    ld(8'h07); op(AFP_OP_DIV, 8'h00, 3'h0); fl(8'h03, 0, 0, 1);
    cmp_byte(partner_reg, 8'h01);
    ld(8'hff); op(AFP_OP_MUL, 8'h00, 3'h0); fl(8'hff, 0, 0, 1);
    $display("test muldiv done");
  endtask
  task automatic t_darot;
    ld(8'h0a); op(AFP_OP_ADD, 8'h00, 3'h0); op(AFP_OP_DA, 8'h00, 3'h0); fl(8'h70, 0, 0, 0);
    ld(8'hff); op(AFP_OP_ADD, 8'h46, 3'h0); op(AFP_OP_DA, 8'h00, 3'h0); fl(8'hab, 1, 0, 1);
    ld(8'h02); op(AFP_OP_RRC, 8'h00, 3'h0); fl(8'h81, 0, 0, 1);
    op(AFP_OP_RLC, 8'h00, 3'h0); fl(8'h02, 1, 0, 1);
    $display("test decimal and rotate done");
  endtask
  task automatic t_port;
    afp_op_t    po[12] = '{AFP_OP_P_ANL, AFP_OP_P_ORL, AFP_OP_P_XRL, AFP_OP_P_CPL, AFP_OP_P_INC,
      AFP_OP_P_DEC, AFP_OP_P_DJNZ, AFP_OP_P_SETB, AFP_OP_P_CLR, AFP_OP_P_MOVC, AFP_OP_P_JBC,
      AFP_OP_P_JBC};
    logic [7:0] ps[12] = '{8'hf0, 8'h05, 8'hff, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    logic [2:0] pb[12] = '{0, 0, 0, 0, 0, 0, 0, 7, 1, 0, 3, 3};
    logic [7:0] pl[12] = '{8'hf0, 8'hf5, 8'h0a, 8'h0b, 8'h0c, 8'h0b, 8'h0a, 8'h8a, 8'h88, 8'h89,
      8'h81, 8'h81};
    logic [11:0] br = 12'h440;
    port_pins = 8'h00;
    for (int i = 0; i < 12; i++) begin
      op(po[i], ps[i], pb[i]);
      cmp_byte(port_latch, pl[i]);
      cmp_bit(branch_taken, br[i]);
    end
    port_pins = 8'h04;
    op(AFP_OP_P_RDB, 8'h00, 3'h2); cmp_bit(bit_result, 1'b1);
    $display("test port done");
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clock);
    #1;
    reset = 1'b0;
    @(posedge clock);
    #1;
    t_arith();
    t_muldiv();
    t_darot();
    t_port();
    give_verdict();
  end
endmodule
